//--- inc/fan_cfg_pkg.sv
// fan monitor register bank: configuration/status layout, reset values
// assumes a single 25 MHz clock domain; no imports, names used as pkg::name
package fan_cfg_pkg;
   localparam logic [7:0] cfg_reset = 8'h00;
   localparam logic [7:0] stat_reset = 8'h00;
   // configuration byte fields
   localparam int cfg_alert_mask = 7;
   localparam int cfg_standby = 6;
   localparam int cfg_overtemp_shutdown_line_pol = 5;
   localparam int cfg_write_prot = 4;
   localparam int cfg_loop_open = 3;
   localparam int cfg_ovin_inhibit = 2;
   localparam int cfg_ovout_mask = 1;
   localparam int cfg_clear_mode = 0;
   // bits 6..3 are write protected
   localparam logic [7:0] cfg_prot_mask = 8'h78;
   // status byte fields
   localparam int st_overheat = 7;
   localparam int st_alert = 6;
   localparam int st_full = 5;
   localparam int st_high = 4;
   localparam int st_low = 3;
   localparam int st_open = 2;
   localparam int st_overtemp_shutdown_line = 1;
   localparam int st_fanfail = 0;
   // read-clear mask 6..2; the status logic applies it to bits 4..2 only
   localparam logic [7:0] st_read_clr = 8'h7C;
   // fan gain byte: bit that selects fan open loop
   localparam int fg_open_loop = 0;
   localparam logic [7:0] cmd_soft_por = 8'hFC;
endpackage : fan_cfg_pkg

//--- src/fan_monitor_config_status.sv
// fan monitor configuration byte and status byte with software reset
// assumes the serial front end decodes commands into one-cycle strobes
//
// Behaviour
// - no conversion starts while supply lockout is active
// - send-byte command FCh resets configuration, status, fan open loop and fault line to power-on values
// - configuration bit 7 masks internal errors from the fault line
// - configuration bit 6 enters standby and stops autonomous conversions
// - configuration bit 5 sets overtemp output polarity, 0 low, 1 high
// - write protect bit 4 blocks config bits 6..3, limit, hysteresis, rate
// - bit 3 opens thermal loop; fan speed holds value, writable only then
// - writing fan gain bit 0 selects fan open loop and sets bit 3
// - bit 2 stops external overtemp level from setting status bit 1
// - bit 1 masks internal overtemp errors from the shutdown output
// - bit 0 zero: status read or alert response clears; one: only response
// - driver over 150C sets bit 7, disables driver until below 140C
// - status bit 6 reads one while the fault line or the external alert line is low
// - status bit 5 shows full scale; reads one in fan open loop
// - status bit 4 set when remote temperature exceeds high limit
// - status bit 3 set when remote temperature is below low limit
// - status bit 2 set when remote diode is open
// - status bit 1 reads one once overtemp shutdown was activated, unless masked by bit 1 or inhibited by bit 2
// - status bit 0 set when tach count exceeds its limit
// - status read clears bits 4..2 unless fault persists; line follows when bit 0 is zero
`timescale 1ns/1ps

module fan_monitor_config_status (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // decoded host commands
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic status_rd,
   input wire logic send_byte,
   input wire logic [7:0] send_cmd,
   input wire logic alert_response,
   input wire logic fan_gain_wr,
   input wire logic [7:0] fan_gain_wdata,
   input wire logic fan_speed_wr,
   input wire logic limit_wr,
   input wire logic hyst_wr,
   input wire logic rate_wr,
   // condition inputs from the measurement side
   input wire logic supply_lockout,
   input wire logic conv_due,
   input wire logic conv_done,
   input wire logic driver_above_150,
   input wire logic driver_below_140,
   input wire logic driver_full,
   input wire logic remote_high,
   input wire logic remote_low,
   input wire logic diode_open,
   input wire logic tach_over_limit,
   input wire logic overtemp_internal,
   input wire logic overtemp_shutdown_line_in,
   input wire logic alert_line_ext_n,
   // register and control outputs
   output logic [7:0] cfg_q,
   output logic [7:0] status_q,
   output logic fan_open_loop_q,
   output logic standby_q,
   output logic conv_start_q,
   output logic driver_off_q,
   output logic fan_speed_we_q,
   output logic limit_we_q,
   output logic hyst_we_q,
   output logic rate_we_q,
   output logic overtemp_shutdown_line_q,
   output logic fault_n_q
);

   ////////////////////////////////////////////////////////////////////////
   logic soft_por;
   logic prot;
   logic [7:0] st_cond;
   logic alert_src;
   logic alert_clear;

   assign soft_por = send_byte && (send_cmd == fan_cfg_pkg::cmd_soft_por);
   assign prot = cfg_q[fan_cfg_pkg::cfg_write_prot];

   // internal fault conditions, gated by the alert mask
   assign alert_src = !cfg_q[fan_cfg_pkg::cfg_alert_mask] &&
      (remote_high || remote_low || diode_open);

   // clear mode picks which requests may drop the fault line
   assign alert_clear = alert_response ||
      (status_rd && !cfg_q[fan_cfg_pkg::cfg_clear_mode]);

   ////////////////////////////////////////////////////////////////////////
   // configuration byte; protected bits keep their value on config writes under write protect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q <= fan_cfg_pkg::cfg_reset;
      end else if (soft_por) begin
         cfg_q <= fan_cfg_pkg::cfg_reset;
      end else begin
         if (cfg_wr) begin
            if (prot) begin
               cfg_q <= (cfg_q & fan_cfg_pkg::cfg_prot_mask) |
                  (cfg_wdata & ~fan_cfg_pkg::cfg_prot_mask);
            end else begin
               cfg_q <= cfg_wdata;
            end
         end
         // fan open loop forces the thermal loop open, even when protected
         if (fan_gain_wr && fan_gain_wdata[fan_cfg_pkg::fg_open_loop]) begin
            cfg_q[fan_cfg_pkg::cfg_loop_open] <= 1'b1;
         end
      end
   end

   property p_soft_power_on_reset;
      @(posedge clk) disable iff (rst)
      soft_por |=> (cfg_q == fan_cfg_pkg::cfg_reset);
   endproperty
   a_soft_power_on_reset: assert property (p_soft_power_on_reset)
      else $error("soft reset left configuration set");

   property p_prot;
      @(posedge clk) disable iff (rst)
      cfg_wr && prot && !fan_gain_wr && !soft_por |=>
         ((cfg_q & fan_cfg_pkg::cfg_prot_mask) ==
         $past(cfg_q & fan_cfg_pkg::cfg_prot_mask));
   endproperty
   a_prot: assert property (p_prot)
      else $error("protected config bits changed");

   property p_keep;
      @(posedge clk) disable iff (rst)
      cfg_wr && prot && !soft_por |=>
         ((cfg_q & ~fan_cfg_pkg::cfg_prot_mask) ==
         ($past(cfg_wdata) & ~fan_cfg_pkg::cfg_prot_mask));
   endproperty
   a_keep: assert property (p_keep)
      else $error("unprotected config bits not written");

   // fan open loop mode from fan gain bit 0
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fan_open_loop_q <= 1'b0;
      end else if (soft_por) begin
         fan_open_loop_q <= 1'b0;
      end else if (fan_gain_wr) begin
         fan_open_loop_q <= fan_gain_wdata[fan_cfg_pkg::fg_open_loop];
      end
   end

   property p_fg;
      @(posedge clk) disable iff (rst)
      fan_gain_wr && fan_gain_wdata[fan_cfg_pkg::fg_open_loop] &&
         !soft_por |=>
         cfg_q[fan_cfg_pkg::cfg_loop_open] && fan_open_loop_q;
   endproperty
   a_fg: assert property (p_fg)
      else $error("fan open loop did not open thermal loop");

   ////////////////////////////////////////////////////////////////////////
   // write enables to neighbouring registers, blocked by protect/closed loop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fan_speed_we_q <= 1'b0;
         limit_we_q <= 1'b0;
         hyst_we_q <= 1'b0;
         rate_we_q <= 1'b0;
      end else begin
         fan_speed_we_q <= fan_speed_wr &&
            cfg_q[fan_cfg_pkg::cfg_loop_open];
         limit_we_q <= limit_wr && !prot;
         hyst_we_q <= hyst_wr && !prot;
         rate_we_q <= rate_wr && !prot;
      end
   end

   property p_loop;
      @(posedge clk) disable iff (rst)
      fan_speed_wr && !cfg_q[fan_cfg_pkg::cfg_loop_open] |=>
         !fan_speed_we_q;
   endproperty
   a_loop: assert property (p_loop)
      else $error("fan speed written in closed loop");

   ////////////////////////////////////////////////////////////////////////
   // conversion gating: standby and supply lockout both hold conversions
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         standby_q <= 1'b0;
         conv_start_q <= 1'b0;
      end else begin
         standby_q <= cfg_q[fan_cfg_pkg::cfg_standby];
         conv_start_q <= conv_due && !supply_lockout &&
            !cfg_q[fan_cfg_pkg::cfg_standby];
      end
   end

   property p_lockout;
      @(posedge clk) disable iff (rst)
      supply_lockout |=> !conv_start_q;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("conversion started under supply lockout");

   property p_standby;
      @(posedge clk) disable iff (rst)
      cfg_q[fan_cfg_pkg::cfg_standby] |=> standby_q && !conv_start_q;
   endproperty
   a_standby: assert property (p_standby)
      else $error("conversion started in standby");

   // driver thermal shutdown with hysteresis between 150 and 140 degrees
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         driver_off_q <= 1'b0;
      end else if (driver_above_150) begin
         driver_off_q <= 1'b1;
      end else if (driver_below_140) begin
         driver_off_q <= 1'b0;
      end
   end

   // driver state and status flag set on the same edge; the flag is checked a cycle later
   sequence s_driver_shown;
      driver_off_q ##1 status_q[fan_cfg_pkg::st_overheat];
   endsequence
   property p_driver;
      @(posedge clk) disable iff (rst)
      driver_above_150 ##1 !soft_por |-> s_driver_shown;
   endproperty
   a_driver: assert property (p_driver)
      else $error("driver overheat not handled");

   ////////////////////////////////////////////////////////////////////////
   // overtemp output: internal error masked by bit 1, polarity by bit 5
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overtemp_shutdown_line_q <= 1'b1; // inactive for the reset polarity
      end else begin
         overtemp_shutdown_line_q <= (overtemp_internal &&
            !cfg_q[fan_cfg_pkg::cfg_ovout_mask]) ==
            cfg_q[fan_cfg_pkg::cfg_overtemp_shutdown_line_pol];
      end
   end

   property p_pol;
      @(posedge clk) disable iff (rst)
      !overtemp_internal ##1 !overtemp_internal |->
         (overtemp_shutdown_line_q == !cfg_q[fan_cfg_pkg::cfg_overtemp_shutdown_line_pol]) ||
         $changed(cfg_q[fan_cfg_pkg::cfg_overtemp_shutdown_line_pol]);
   endproperty
   a_pol: assert property (p_pol)
      else $error("overtemp output polarity wrong");

   property p_ovmask;
      @(posedge clk) disable iff (rst)
      cfg_q[fan_cfg_pkg::cfg_ovout_mask] |=>
         overtemp_shutdown_line_q ==
         !$past(cfg_q[fan_cfg_pkg::cfg_overtemp_shutdown_line_pol]);
   endproperty
   a_ovmask: assert property (p_ovmask)
      else $error("masked overtemp error reached the output");

   // fault line latches on a source at conversion end, drops on a clear once the fault ended;
   // a persisting fault holds the line low, and a clear is ignored until it ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_n_q <= 1'b1;
      end else if (soft_por) begin
         fault_n_q <= 1'b1;
      end else if (alert_src && (conv_done || fault_n_q == 1'b0)) begin
         fault_n_q <= 1'b0;
      end else if (alert_clear && !alert_src) begin
         fault_n_q <= 1'b1;
      end else if (alert_clear) begin
         fault_n_q <= 1'b1; // re-raised at next conversion end
      end
   end

   // line pulled low first, the status copy one cycle later
   sequence s_fault_shown;
      !fault_n_q ##1 status_q[fan_cfg_pkg::st_alert];
   endsequence
   property p_alert;
      @(posedge clk) disable iff (rst)
      alert_src && conv_done && !soft_por ##1 !soft_por |-> s_fault_shown;
   endproperty
   a_alert: assert property (p_alert)
      else $error("fault line or alert flag not raised");

   property p_amask;
      @(posedge clk) disable iff (rst)
      cfg_q[fan_cfg_pkg::cfg_alert_mask] && fault_n_q |=> fault_n_q;
   endproperty
   a_amask: assert property (p_amask)
      else $error("masked error drove the fault line");

   ////////////////////////////////////////////////////////////////////////
   // live conditions feeding the status flags
   always_comb begin
      st_cond = 8'h00;
      st_cond[fan_cfg_pkg::st_overheat] = driver_above_150 || driver_off_q;
      st_cond[fan_cfg_pkg::st_alert] = !fault_n_q || !alert_line_ext_n;
      st_cond[fan_cfg_pkg::st_full] = driver_full || fan_open_loop_q;
      st_cond[fan_cfg_pkg::st_high] = remote_high;
      st_cond[fan_cfg_pkg::st_low] = remote_low;
      st_cond[fan_cfg_pkg::st_open] = diode_open;
      st_cond[fan_cfg_pkg::st_overtemp_shutdown_line] = (overtemp_internal &&
         !cfg_q[fan_cfg_pkg::cfg_ovout_mask]) ||
         (overtemp_shutdown_line_in &&
         !cfg_q[fan_cfg_pkg::cfg_ovin_inhibit]);
      st_cond[fan_cfg_pkg::st_fanfail] = tach_over_limit;
   end

   // status byte: sticky 4..1, read clears 4..2; a new event wins over the read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= fan_cfg_pkg::stat_reset;
      end else if (soft_por) begin
         status_q <= fan_cfg_pkg::stat_reset;
      end else begin
         status_q[fan_cfg_pkg::st_overheat] <=
            st_cond[fan_cfg_pkg::st_overheat];
         status_q[fan_cfg_pkg::st_alert] <=
            st_cond[fan_cfg_pkg::st_alert];
         status_q[fan_cfg_pkg::st_full] <=
            st_cond[fan_cfg_pkg::st_full];
         status_q[fan_cfg_pkg::st_fanfail] <=
            st_cond[fan_cfg_pkg::st_fanfail];
         for (int i = fan_cfg_pkg::st_overtemp_shutdown_line; i <= fan_cfg_pkg::st_high;
              i++) begin
            if (st_cond[i]) begin
               status_q[i] <= 1'b1;
            end else if (status_rd && fan_cfg_pkg::st_read_clr[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags show their cause one cycle later
   property p_full;
      @(posedge clk) disable iff (rst)
      fan_open_loop_q && !soft_por |=> status_q[fan_cfg_pkg::st_full];
   endproperty
   a_full: assert property (p_full)
      else $error("full scale flag low in fan open loop");

   property p_high;
      @(posedge clk) disable iff (rst)
      remote_high && !soft_por |=> status_q[fan_cfg_pkg::st_high];
   endproperty
   a_high: assert property (p_high)
      else $error("high limit flag not set");

   property p_readclr;
      @(posedge clk) disable iff (rst)
      status_rd && !remote_high |=> !status_q[fan_cfg_pkg::st_high];
   endproperty
   a_readclr: assert property (p_readclr)
      else $error("ended high limit flag survived a status read");

endmodule : fan_monitor_config_status

//--- verif/host_cmd_model.sv
// host side model: issues decoded register commands, one at a time
// assumes the bench calls issue() and that clk is the block's clock
`timescale 1ns/1ps
module host_cmd_model (
   // clock
   input wire logic clk,
   // decoded commands toward the register bank
   output logic cfg_wr,
   output logic [7:0] cfg_wdata,
   output logic status_rd,
   output logic send_byte,
   output logic [7:0] send_cmd,
   output logic alert_response,
   output logic fan_gain_wr,
   output logic [7:0] fan_gain_wdata,
   output logic fan_speed_wr,
   output logic limit_wr,
   output logic hyst_wr,
   output logic rate_wr
);
   logic [8:0] strobe = 9'h000;
   logic [7:0] data = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // one-hot vector, so two commands never share a cycle
   assign {rate_wr, hyst_wr, limit_wr, fan_speed_wr, fan_gain_wr,
      alert_response, send_byte, status_rd, cfg_wr} = strobe;
   // one data bus; send-byte carries only the command code
   assign cfg_wdata = data;
   assign send_cmd = data;
   assign fan_gain_wdata = data;
   // strobe held over one sampling edge; stale data shown inverted
   task automatic issue(input int k, input logic [7:0] d);
      @(posedge clk);
      #1;
      strobe = 9'h001 << k;
      data = d;
      @(posedge clk);
      #1;
      strobe = 9'h000;
      data = ~d;
   endtask : issue
endmodule : host_cmd_model

//--- verif/fan_monitor_config_status_tb.sv
// self-checking bench for the configuration and status byte bank
// assumes host_cmd_model drives every command strobe of the block
`timescale 1ns/1ps
module fan_monitor_config_status_tb;
   typedef struct packed {
      logic [7:0] cfg;
      logic [12:0] cond;
      logic [7:0] st;
   } row_t;
   // driver cool and external fault line released
   localparam logic [12:0] idle = 13'h101;
   logic clk, rst;
   logic cfg_wr, status_rd, send_byte, alert_response, fan_gain_wr;
   logic fan_speed_wr, limit_wr, hyst_wr, rate_wr;
   logic [7:0] cfg_wdata, send_cmd, fan_gain_wdata, cfg_q, status_q;
   logic supply_lockout, conv_due, conv_done, driver_above_150;
   logic driver_below_140, driver_full, remote_high, remote_low;
   logic diode_open, tach_over_limit, overtemp_internal;
   logic overtemp_shutdown_line_in, alert_line_ext_n;
   logic fan_open_loop_q, standby_q, conv_start_q, driver_off_q;
   logic fan_speed_we_q, limit_we_q, hyst_we_q, rate_we_q;
   logic overtemp_shutdown_line_q, fault_n_q;
   logic [12:0] cond = 13'h101;
   int fails = 0;
   int n_compared = 0;
   row_t rows [14] = '{
      '{8'h00, 13'h181, 8'h20},
      '{8'h00, 13'h141, 8'h10},
      '{8'h00, 13'h121, 8'h08},
      '{8'h00, 13'h111, 8'h04},
      '{8'h00, 13'h109, 8'h01},
      '{8'h00, 13'h103, 8'h02},
      '{8'h04, 13'h103, 8'h00},
      '{8'h00, 13'h105, 8'h02},
      '{8'h02, 13'h105, 8'h00},
      '{8'h00, 13'h100, 8'h40},
      '{8'h80, 13'h541, 8'h10},
      '{8'h00, 13'h541, 8'h50},
      '{8'h20, 13'h105, 8'h02},
      '{8'h20, 13'h101, 8'h00}};
   ////////////////////////////////////////////////////////////////////////
   // condition inputs packed so that a row sets them all at once
   assign {supply_lockout, conv_due, conv_done, driver_above_150,
      driver_below_140, driver_full, remote_high, remote_low, diode_open,
      tach_over_limit, overtemp_internal, overtemp_shutdown_line_in,
      alert_line_ext_n} = cond;
   fan_monitor_config_status dut_u (.*);
   host_cmd_model host_u (.*);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR %0t got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask : chk
   task automatic wrap_up();
      if (fails == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      wrap_up();
   end
   // main sequence: table rows first, then the awkward cases
   initial begin
      rst = 1'b1;
      tick(16);
      chk(cfg_q, 8'h00);
      chk(status_q | {7'h00, ~fault_n_q}, 8'h00);
      rst = 1'b0;
      foreach (rows[i]) begin
         host_u.issue(2, 8'hFC);
         host_u.issue(0, rows[i].cfg);
         cond = rows[i].cond;
         tick(3);
         chk(status_q, rows[i].st);
         if (!cond[1]) chk({7'h00, overtemp_shutdown_line_q}, {7'h00,
            ~((cond[2] & ~rows[i].cfg[1]) ^ rows[i].cfg[5])});
         cond = idle;
      end
      // enables: unprotected then protected with the loop open
      for (int p = 0; p < 2; p++) begin
         host_u.issue(0, p ? 8'h18 : 8'h00);
         for (int k = 5; k < 9; k++) begin
            host_u.issue(k, 8'h00);
            chk({4'h0, rate_we_q, hyst_we_q, limit_we_q, fan_speed_we_q},
               {4'h0, (4'h1 << (k - 5)) & (p ? 4'h1 : 4'hE)});
         end
      end
      host_u.issue(0, 8'hFF);
      chk(cfg_q, 8'h9F);
      host_u.issue(2, 8'hFC);
      chk(cfg_q, 8'h00);
      host_u.issue(4, 8'h01);
      tick(2);
      chk(cfg_q | {7'h00, fan_open_loop_q}, 8'h09);
      chk(status_q & 8'h20, 8'h20);
      // standby and lockout both hold back a conversion start
      host_u.issue(0, 8'h40);
      tick(1);
      cond = 13'h901;
      tick(1);
      chk({6'h00, standby_q, conv_start_q}, 8'h02);
      cond = idle;
      host_u.issue(0, 8'h00);
      tick(1);
      cond = 13'h1901;
      tick(1);
      chk({7'h00, conv_start_q}, 8'h00);
      cond = 13'h901;
      tick(1);
      chk({7'h00, conv_start_q}, 8'h01);
      // overheat latches until the driver cools below the low mark
      cond = 13'h201;
      tick(2);
      cond = 13'h001;
      tick(2);
      chk(status_q & 8'h80 | {7'h00, driver_off_q}, 8'h81);
      cond = idle;
      tick(3);
      chk(status_q & 8'h80 | {7'h00, driver_off_q}, 8'h00);
      // fault line clearing in both clear modes
      host_u.issue(0, 8'h01);
      cond = 13'h541;
      tick(2);
      cond = idle;
      tick(2);
      chk(status_q & 8'h50 | {7'h00, fault_n_q}, 8'h50);
      host_u.issue(1, 8'h00);
      tick(2);
      chk(status_q & 8'h10 | {7'h00, fault_n_q}, 8'h00);
      host_u.issue(3, 8'h00);
      tick(2);
      chk({7'h00, fault_n_q}, 8'h01);
      host_u.issue(0, 8'h00);
      cond = 13'h541;
      tick(2);
      cond = 13'h141;
      host_u.issue(1, 8'h00);
      tick(2);
      chk(status_q & 8'h10, 8'h10);
      cond = 13'h541;
      tick(2);
      chk({7'h00, fault_n_q}, 8'h00);
      cond = idle;
      host_u.issue(1, 8'h00);
      chk(status_q & 8'h10 | {7'h00, fault_n_q}, 8'h01);
      wrap_up();
   end
endmodule : fan_monitor_config_status_tb
